// *** src/scd_pkg.sv ***
// Constants and carrier types for the system clock divider
package scd_pkg;

  // ------------------------------------------------------------
  // Division control register layout
  // ------------------------------------------------------------
  localparam int         CTRL_WIDTH        = 8;
  localparam logic [7:0] CTRL_RESET        = 8'hFC;
  localparam logic [5:0] CTRL_FIXED_ONES   = 6'h3F;
  localparam int         RATIO_LSB         = 0;
  localparam int         RATIO_MSB         = 1;
  localparam int         RATIO_WIDTH       = 2;

  // Ratio select codes
  localparam logic [1:0] RATIO_BY1         = 2'h0;
  localparam logic [1:0] RATIO_BY2         = 2'h1;
  localparam logic [1:0] RATIO_BY4         = 2'h2;
  localparam logic [1:0] RATIO_BY8         = 2'h3;

  // ------------------------------------------------------------
  // Divider and prescaler sizing
  // ------------------------------------------------------------
  localparam int         HALF_CNT_WIDTH    = 3;
  // Last half-period count for each ratio code
  localparam logic [2:0] HALF_LAST_BY1     = 3'h0;
  localparam logic [2:0] HALF_LAST_BY2     = 3'h1;
  localparam logic [2:0] HALF_LAST_BY4     = 3'h3;
  localparam logic [2:0] HALF_LAST_BY8     = 3'h7;
  localparam int         PRESCALE_STAGES   = 12;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int         CLK_PERIOD_PS     = 10000;
  localparam int         SETTLE_TIME_US    = 500;
  localparam int         SETTLE_CYCLES     = (SETTLE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Clock output pin controls
  typedef struct packed {
    logic mode_allows;
    logic clock_output_stop;
  } scd_pin_ctrl_t;

  // Pin drive level and output enable
  typedef struct packed {
    logic level;
    logic oe;
  } scd_pin_drive_t;

endpackage

// *** src/scd_prescaler.sv ***
// Prescaler chain deriving system clock divided by two up to 4096
`timescale 1ns/10ps
`default_nettype none

module scd_prescaler #(
  parameter int STAGES = 12
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              phi_rise,
  output logic [STAGES-1:0]      prescale_tick
);

  logic [STAGES-1:0] count;
  logic [STAGES-1:0] next_count;
  logic [STAGES-1:0] next_prescale_tick;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_count = count;
    if (phi_rise)
    begin
      next_count = count + {{(STAGES-1){1'b0}}, 1'b1};
    end
  end

  genvar k;
  generate
    for (k = 0; k < STAGES; k++)
    begin : g_tap
      always_comb
      begin
        next_prescale_tick[k] = phi_rise & (&count[k:0]);
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      count         <= '0;
      prescale_tick <= '0;
    end
    else
    begin
      count         <= next_count;
      prescale_tick <= next_prescale_tick;
    end
  end

endmodule

`default_nettype wire

// *** src/scd_top.sv ***
// Clock pulse generator: duty stage, ratio divider, prescalers and clock pin
//
// Summary of operation
// - System clock is duty-adjusted oscillator divided by 1, 2, 4 or 8.
// - Duty adjustment stage sits ahead of the divider; divider steps on it.
// - Ratio may be rewritten while running; no stop or reset needed.
// - Clock pin follows the newly selected ratio.
// - System clock feeds prescalers giving divide by 2 up to 4096.
// - Clock pin drive depends on operating mode and clock output stop bit.
// - Ratio code 00 /1, 01 /2, 10 /4, 11 /8.
// - Control register reset by reset and hardware standby, kept in software standby.
// - Upper six control bits ignore writes and read as one.
`timescale 1ns/10ps
`default_nettype none

module scd_top
  import scd_pkg::*;
#(
  parameter int PRESCALE_STAGES_P = scd_pkg::PRESCALE_STAGES
) (
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic                              hardware_standby,
  input  wire logic                              software_standby,
  input  wire logic                              ratio_write,
  input  wire logic [scd_pkg::CTRL_WIDTH-1:0]    ratio_write_data,
  input  wire scd_pkg::scd_pin_ctrl_t            pin_ctrl,
  output logic [scd_pkg::CTRL_WIDTH-1:0]         division_control_register,
  output logic [scd_pkg::RATIO_WIDTH-1:0]        active_ratio,
  output logic                                   system_clock,
  output logic                                   system_clock_rise,
  output var scd_pkg::scd_pin_drive_t            system_clock_pin,
  output logic [PRESCALE_STAGES_P-1:0]           prescale_tick
);

  import scd_pkg::*;

  logic [CTRL_WIDTH-1:0]     next_division_control_register;
  logic [RATIO_WIDTH-1:0]    next_active_ratio;
  logic [HALF_CNT_WIDTH-1:0] half_count;
  logic [HALF_CNT_WIDTH-1:0] next_half_count;
  logic [HALF_CNT_WIDTH-1:0] half_last;
  logic                      next_system_clock;
  logic                      next_system_clock_rise;
  scd_pin_drive_t            next_system_clock_pin;
  logic                      local_reset;

  assign local_reset = !rst_b || hardware_standby;

  // ------------------------------------------------------------
  // Division control register
  // ------------------------------------------------------------
  always_comb
  begin
    next_division_control_register = division_control_register;
    if (ratio_write)
    begin
      next_division_control_register = {CTRL_FIXED_ONES, ratio_write_data[RATIO_MSB:RATIO_LSB]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (local_reset)
    begin
      division_control_register <= CTRL_RESET;
    end
    else
    begin
      division_control_register <= next_division_control_register;
    end
  end

  // ------------------------------------------------------------
  // Duty stage and ratio divider
  // ------------------------------------------------------------
  always_comb
  begin
    unique case (active_ratio)
      RATIO_BY1: half_last = HALF_LAST_BY1;
      RATIO_BY2: half_last = HALF_LAST_BY2;
      RATIO_BY4: half_last = HALF_LAST_BY4;
      RATIO_BY8: half_last = HALF_LAST_BY8;
    endcase
  end

  always_comb
  begin
    // Each clk edge ends one half period of the duty-adjusted clock; the divider counts those
    next_half_count        = half_count + 3'h1;
    next_system_clock      = system_clock;
    next_active_ratio      = active_ratio;
    next_system_clock_rise = 1'b0;
    // One half period of the system clock is one to eight duty-stage half periods
    if (half_count == half_last)
    begin
      next_half_count   = 3'h0;
      next_system_clock = ~system_clock;
      if (!system_clock)
      begin
        next_system_clock_rise = 1'b1;
      end
      else
      begin
        // Falling edge closes a full period; only here may the ratio change
        next_active_ratio = division_control_register[RATIO_MSB:RATIO_LSB];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (local_reset)
    begin
      half_count        <= 3'h0;
      system_clock      <= 1'b0;
      system_clock_rise <= 1'b0;
      active_ratio      <= RATIO_BY1;
    end
    else
    begin
      half_count        <= next_half_count;
      system_clock      <= next_system_clock;
      system_clock_rise <= next_system_clock_rise;
      active_ratio      <= next_active_ratio;
    end
  end

  // ------------------------------------------------------------
  // Clock output pin
  // ------------------------------------------------------------
  always_comb
  begin
    // Software standby parks the pin high; hardware standby releases it
    next_system_clock_pin.level = software_standby ? 1'b1 : next_system_clock;
    next_system_clock_pin.oe    = pin_ctrl.mode_allows && !pin_ctrl.clock_output_stop
                                  && !hardware_standby;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      system_clock_pin <= '0;
    end
    else
    begin
      system_clock_pin <= next_system_clock_pin;
    end
  end

  // ------------------------------------------------------------
  // Prescalers
  // ------------------------------------------------------------
  scd_prescaler #(
    .STAGES        (PRESCALE_STAGES_P)
  ) u_prescaler (
    .clk           (clk),
    .rst_b         (rst_b && !hardware_standby),
    .phi_rise      (system_clock_rise),
    .prescale_tick (prescale_tick)
  );

endmodule

`default_nettype wire

// *** testbench/scd_source.sv ***
// Reset source model for the system clock divider
`timescale 1ns/10ps
`default_nettype none
module scd_source #(
  parameter int HOLD = scd_pkg::SETTLE_CYCLES
) (
  input  wire logic clk,
  output logic      rst_b
);
  int n = 0;
  // Reset stays low until the clock has settled
  assign rst_b = (n >= HOLD);
  always @(posedge clk) n <= #1 n + 1;
endmodule
`default_nettype wire

// *** testbench/scd_top_sva.sv ***
// Port checker for the system clock divider
`timescale 1ns/10ps
`default_nettype none
module scd_top_sva
  import scd_pkg::*;
#(
  parameter int PRESCALE_STAGES_P = 12
) (
  input wire logic                       clk,
  input wire logic                       rst_b,
  input wire logic                       hardware_standby,
  input wire logic                       software_standby,
  input wire logic                       ratio_write,
  input wire logic [7:0]                 ratio_write_data,
  input wire scd_pkg::scd_pin_ctrl_t     pin_ctrl,
  input wire logic [7:0]                 division_control_register,
  input wire logic [1:0]                 active_ratio,
  input wire logic                       system_clock,
  input wire logic                       system_clock_rise,
  input wire scd_pkg::scd_pin_drive_t    system_clock_pin,
  input wire logic [PRESCALE_STAGES_P-1:0] prescale_tick
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b || hardware_standby);
  sequence s_rise(logic [1:0] c);
    active_ratio == c && $rose(system_clock);
  endsequence
  a_fixed_ones: assert property (division_control_register[7:2] == 6'h3F)
    else $error("upper control bits not one");
  a_write_take: assert property (ratio_write |=>
    division_control_register == {6'h3F, $past(ratio_write_data[1:0])})
    else $error("write not taken");
  a_sw_keep: assert property (software_standby && !ratio_write |=> $stable(division_control_register))
    else $error("register lost in software standby");
  a_hw_reset: assert property (@(posedge clk) disable iff (!rst_b) hardware_standby |=>
    division_control_register == CTRL_RESET && !system_clock_pin.oe) else $error("hardware standby");
  a_pin_oe: assert property ($past(rst_b) |-> system_clock_pin.oe ==
    $past(pin_ctrl.mode_allows && !pin_ctrl.clock_output_stop && !hardware_standby)) else $error("pin enable");
  a_pin_level: assert property ($past(rst_b) && !$past(hardware_standby) |->
    system_clock_pin.level == ($past(software_standby) ? 1'b1 : system_clock)) else $error("pin level");
  a_rise_pulse: assert property ($past(rst_b) && !$past(hardware_standby) |->
    system_clock_rise == $rose(system_clock)) else $error("rise pulse");
  a_half_by1: assert property (s_rise(2'h0) |-> system_clock[*1] ##1 !system_clock)
    else $error("half period 1");
  a_half_by2: assert property (s_rise(2'h1) |-> system_clock[*2] ##1 !system_clock)
    else $error("half period 2");
  a_half_by4: assert property (s_rise(2'h2) |-> system_clock[*4] ##1 !system_clock)
    else $error("half period 4");
  a_half_by8: assert property (s_rise(2'h3) |-> system_clock[*8] ##1 !system_clock)
    else $error("half period 8");
  a_tick_rise: assert property (prescale_tick[0] |-> $past(system_clock_rise))
    else $error("tick not after rise");
  a_ratio_edge: assert property (!$stable(active_ratio) |-> $fell(system_clock))
    else $error("ratio changed off a period boundary");
  a_ratio_adopt: assert property ($fell(system_clock) |->
    active_ratio == $past(division_control_register[1:0])) else $error("ratio not adopted at period end");
endmodule
`default_nettype wire

// *** testbench/system_clock_divider_test.sv ***
// Testbench for the system clock divider
`timescale 1ns/10ps
`default_nettype none
module system_clock_divider_test;
  import scd_pkg::*;
  logic           clk = 1'b0;
  logic           rst_b;
  logic           hardware_standby = 1'b0;
  logic           software_standby = 1'b0;
  logic           ratio_write = 1'b0;
  logic [7:0]     ratio_write_data = 8'h00;
  scd_pin_ctrl_t  pin_ctrl = 2'h2;
  logic [7:0]     division_control_register;
  logic [1:0]     active_ratio;
  logic           system_clock;
  logic           system_clock_rise;
  scd_pin_drive_t system_clock_pin;
  logic [11:0]    prescale_tick;
  int             err_count = 0;
  int             n_tests = 0;
  always #5 clk = ~clk;
  scd_source #(.HOLD(6)) u_src (.clk(clk), .rst_b(rst_b));
  scd_top uut (.clk(clk), .rst_b(rst_b), .hardware_standby(hardware_standby),
    .software_standby(software_standby), .ratio_write(ratio_write), .ratio_write_data(ratio_write_data),
    .pin_ctrl(pin_ctrl), .division_control_register(division_control_register), .active_ratio(active_ratio),
    .system_clock(system_clock), .system_clock_rise(system_clock_rise), .system_clock_pin(system_clock_pin),
    .prescale_tick(prescale_tick));
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_code(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: ratio got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_count(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: count got %0d expected %0d", $time, got, exp);
    end
  endtask
  task end_sim;
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_ratio(input logic [1:0] c);
    int   i;
    int   r;
    logic p;
    ratio_write = 1'b1;
    ratio_write_data = {6'h15, c};
    cyc(1);
    ratio_write = 1'b0;
    chk_byte(division_control_register, {CTRL_FIXED_ONES, c});
    for (i = 0; i < 40 && active_ratio !== c; i++) cyc(1);
    chk_code(active_ratio, c);
    if (i == 40) end_sim();
    r = 0;
    p = system_clock_pin.level;
    for (i = 0; i < 64; i++)
    begin
      cyc(1);
      if (system_clock_pin.level === 1'b1 && p === 1'b0) r++;
      p = system_clock_pin.level;
    end
    chk_count(16'(r), 16'(32 >> c));
    chk_bit(system_clock_pin.oe, 1'b1);
  endtask
  // Cycles between two ticks of one prescaler tap
  task gap(input int k, input logic [15:0] exp);
    int i;
    int g;
    for (i = 0; i < 9000 && prescale_tick[k] !== 1'b1; i++) cyc(1);
    chk_bit(prescale_tick[k], 1'b1);
    if (i == 9000) end_sim();
    cyc(1);
    for (g = 1; g < 9000 && prescale_tick[k] !== 1'b1; g++) cyc(1);
    chk_count(16'(g), exp);
    if (g == 9000) end_sim();
  endtask
  task t_standby;
    software_standby = 1'b1;
    cyc(2);
    chk_bit(system_clock_pin.level, 1'b1);
    chk_byte(division_control_register, {CTRL_FIXED_ONES, RATIO_BY8});
    software_standby = 1'b0;
    pin_ctrl.clock_output_stop = 1'b1;
    cyc(2);
    chk_bit(system_clock_pin.oe, 1'b0);
    pin_ctrl = 2'h0;
    cyc(2);
    chk_bit(system_clock_pin.oe, 1'b0);
    pin_ctrl = 2'h2;
    cyc(2);
    chk_bit(system_clock_pin.oe, 1'b1);
    hardware_standby = 1'b1;
    cyc(2);
    chk_byte(division_control_register, CTRL_RESET);
    chk_bit(system_clock_pin.oe, 1'b0);
    hardware_standby = 1'b0;
    cyc(4);
    chk_code(active_ratio, RATIO_BY1);
    chk_bit(system_clock_pin.oe, 1'b1);
  endtask
  initial
  begin
    cyc(6);
    chk_byte(division_control_register, CTRL_RESET);
    chk_bit(system_clock_pin.oe, 1'b0);
    for (int c = 3; c >= 0; c--) t_ratio(2'(c));
    gap(0, 16'h0004);
    gap(11, 16'h2000);
    t_ratio(RATIO_BY8);
    t_standby();
    end_sim();
  end
endmodule
bind scd_top scd_top_sva #(.PRESCALE_STAGES_P(PRESCALE_STAGES_P)) u_sva (.clk(clk), .rst_b(rst_b),
  .hardware_standby(hardware_standby), .software_standby(software_standby), .ratio_write(ratio_write),
  .ratio_write_data(ratio_write_data), .pin_ctrl(pin_ctrl), .division_control_register(division_control_register),
  .active_ratio(active_ratio), .system_clock(system_clock), .system_clock_rise(system_clock_rise),
  .system_clock_pin(system_clock_pin), .prescale_tick(prescale_tick));
`default_nettype wire
